// >>> rtl/cpt_conn.sv
// One connection's power transmitter state machine
`default_nettype none
`include "cpt_defines.svh"
module cpt_conn (
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire cpt_pkg::cpt_cmd_t cmd,
   input  wire cpt_pkg::cpt_sense_t sense,
   input  wire logic              supply_ok,
   input  wire logic [`CPT_CNT_W-1:0] retry_cycles,
   output logic                   switch_closed,
   output logic                   detect_start,
   output logic                   power_config_state,
   output logic [1:0]             power_run_state
);
   typedef struct packed {
      cpt_pkg::cpt_state_t       st;
      logic                      cfg;
      logic [`CPT_CNT_W-1:0]     wait_cnt;
      logic [`CPT_CNT_W-1:0]     drop_cnt;
      logic [`CPT_CNT_W-1:0]     win_cnt;
      logic [`CPT_ACC_W-1:0]     acc;
      logic                      running;
      logic                      sw;
      logic                      start;
      logic [1:0]                run;
   } cpt_conn_state_t;

   cpt_conn_state_t s;
   cpt_conn_state_t next_s;

   logic [`CPT_ACC_W-1:0] thresh;
   assign thresh = `CPT_ACC_W'(`CPT_AVG_WIN_CYC) * `CPT_ACC_W'(`CPT_MIN_CURRENT_MA);

   always_comb begin
      next_s       = s;
      next_s.start = 1'b0;
      case (s.st)
         cpt_pkg::CPT_OFF: begin
            next_s.sw = 1'b0;
            if (cmd.auto_power_cmd) begin
               next_s.st      = cpt_pkg::CPT_DETECT;
               next_s.cfg     = `CPT_CFG_AUTO;
               next_s.start   = 1'b1;
               next_s.running = 1'b1;
               next_s.wait_cnt = '0;
            end
         end
         cpt_pkg::CPT_DETECT: begin
            next_s.sw = 1'b0;
            if (cmd.power_off_cmd) begin
               next_s.st  = cpt_pkg::CPT_OFF;
               next_s.cfg = `CPT_CFG_OFF;
            end else if (!s.running) begin
               // Retry gap before the next attempt
               if (s.wait_cnt >= retry_cycles) begin
                  next_s.start   = 1'b1;
                  next_s.running = 1'b1;
                  next_s.wait_cnt = '0;
               end else begin
                  next_s.wait_cnt = s.wait_cnt + `CPT_CNT_W'(1);
               end
            end else if (sense.detect_done) begin
               next_s.running = 1'b0;
               if (sense.detect_ok && supply_ok) begin
                  next_s.st       = cpt_pkg::CPT_POWERED;
                  next_s.sw       = 1'b1;
                  next_s.drop_cnt = '0;
                  next_s.win_cnt  = '0;
                  next_s.acc      = '0;
               end
            end
         end
         cpt_pkg::CPT_POWERED: begin
            next_s.acc     = s.acc + `CPT_ACC_W'(sense.iout_ma);
            next_s.win_cnt = s.win_cnt + `CPT_CNT_W'(1);
            next_s.drop_cnt = sense.vout_dropped ? s.drop_cnt + `CPT_CNT_W'(1) : '0;
            if (cmd.power_off_cmd) begin
               next_s.st  = cpt_pkg::CPT_OFF;
               next_s.cfg = `CPT_CFG_OFF;
               next_s.sw  = 1'b0;
            end else if (s.drop_cnt >= `CPT_CNT_W'(`CPT_DROP_CYC)) begin
               next_s.st = cpt_pkg::CPT_TRIPPED;
               next_s.sw = 1'b0;
            end else if (!supply_ok) begin
               next_s.st = cpt_pkg::CPT_DETECT;
               next_s.sw = 1'b0;
               next_s.running = 1'b0;
               next_s.wait_cnt = '0;
            end else if (s.win_cnt == `CPT_CNT_W'(`CPT_AVG_WIN_CYC - 1)) begin
               // Judge the full window sum before the accumulator restarts
               if (next_s.acc < thresh) begin
                  next_s.st = cpt_pkg::CPT_DETECT;
                  next_s.sw = 1'b0;
                  next_s.running = 1'b0;
                  next_s.wait_cnt = '0;
               end
               next_s.win_cnt = '0;
               next_s.acc     = '0;
            end
         end
         cpt_pkg::CPT_TRIPPED: begin
            next_s.sw = 1'b0;
            if (cmd.power_off_cmd) begin
               next_s.st  = cpt_pkg::CPT_OFF;
               next_s.cfg = `CPT_CFG_OFF;
            end else if (cmd.trip_clear_cmd) begin
               next_s.st       = cpt_pkg::CPT_DETECT;
               next_s.running  = 1'b0;
               next_s.wait_cnt = '0;
            end
         end
         default: next_s.st = cpt_pkg::CPT_OFF;
      endcase
      if (next_s.st == cpt_pkg::CPT_TRIPPED) begin
         next_s.run = `CPT_RUN_TRIPPED;
      end else if (next_s.st == cpt_pkg::CPT_POWERED) begin
         next_s.run = `CPT_RUN_ON;
      end else begin
         next_s.run = `CPT_RUN_OFF;
      end
   end

   // Powered-up state is auto and detecting
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s          <= '0;
         s.st       <= cpt_pkg::CPT_DETECT;
         s.cfg      <= `CPT_CFG_AUTO;
      end else begin
         s <= next_s;
      end
   end

   assign switch_closed      = s.sw;
   assign detect_start       = s.start;
   assign power_config_state = s.cfg;
   assign power_run_state    = s.run;
endmodule
`default_nettype wire

// >>> rtl/cpt_defines.svh
// Constants for the cable power transmitter controller
`ifndef CPT_DEFINES_SVH
`define CPT_DEFINES_SVH

`define CPT_CLK_HZ          100000000
`define CPT_AVG_WIN_MS      300
`define CPT_AVG_WIN_CYC     ((`CPT_CLK_HZ / 1000) * `CPT_AVG_WIN_MS)
`define CPT_MIN_CURRENT_MA  8
`define CPT_DROP_MS         20
`define CPT_DROP_CYC        ((`CPT_CLK_HZ / 1000) * `CPT_DROP_MS + 1)
`define CPT_RETRY_CYC       1000
`define CPT_DETECT_TMO_CYC  100000
`define CPT_CUR_W           12
`define CPT_CNT_W           32
`define CPT_ACC_W           48
`define CPT_NCONN           4
`define CPT_TRIG_CONN       0
`define CPT_CFG_OFF         1'h0
`define CPT_CFG_AUTO        1'h1
`define CPT_RUN_OFF         2'h0
`define CPT_RUN_ON          2'h1
`define CPT_RUN_TRIPPED     2'h2

`endif

// >>> rtl/cpt_pkg.sv
// Types for the cable power transmitter controller
`default_nettype none
`include "cpt_defines.svh"
package cpt_pkg;
   typedef enum logic [1:0] {
      CPT_OFF,
      CPT_DETECT,
      CPT_POWERED,
      CPT_TRIPPED
   } cpt_state_t;

   // Commands from software, one-cycle pulses
   typedef struct packed {
      logic auto_power_cmd;
      logic power_off_cmd;
      logic trip_clear_cmd;
   } cpt_cmd_t;

   // Live signals from the analog front end
   typedef struct packed {
      logic                   detect_done;
      logic                   detect_ok;
      logic                   vout_dropped;
      logic [`CPT_CUR_W-1:0]  iout_ma;
   } cpt_sense_t;
endpackage
`default_nettype wire

// >>> rtl/cpt_top.sv
// Cable power transmitter controller, all connections
`default_nettype none
`include "cpt_defines.svh"
module cpt_top (
   input  wire logic                               mclk,
   input  wire logic                               rst_n,
   input  wire cpt_pkg::cpt_cmd_t [`CPT_NCONN-1:0] cmd,
   input  wire cpt_pkg::cpt_sense_t [`CPT_NCONN-1:0] sense,
   input  wire logic                               aux_supply_connected,
   input  wire logic                               supply_input_ok,
   input  wire logic [`CPT_CNT_W-1:0]              retry_cycles,
   input  wire logic                               host_trigger,
   output logic [`CPT_NCONN-1:0]                   switch_closed,
   output logic [`CPT_NCONN-1:0]                   detect_start,
   output logic [`CPT_NCONN-1:0]                   power_config_state,
   output logic [2*`CPT_NCONN-1:0]                 power_run_state,
   output logic                                    trigger_out
);
   // Supply pins come from outside; two flops before use
   logic [1:0] aux_sync;
   logic [1:0] ok_sync;
   logic       trig_meta;
   logic       trig_sync;
   logic       supply_ok;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         aux_sync    <= 2'h0;
         ok_sync     <= 2'h0;
         trig_meta   <= 1'h0;
         trig_sync   <= 1'h0;
         trigger_out <= 1'h0;
      end else begin
         aux_sync    <= {aux_sync[0], aux_supply_connected};
         ok_sync     <= {ok_sync[0], supply_input_ok};
         trig_meta   <= host_trigger;
         trig_sync   <= trig_meta;
         // Host-to-camera direction only, connection 0 only
         trigger_out <= trig_sync;
      end
   end

   assign supply_ok = aux_sync[1] & ok_sync[1];

   genvar i;
   generate
      for (i = 0; i < `CPT_NCONN; i = i + 1) begin : g_conn
         cpt_conn u_conn (
            .mclk               (mclk),
            .rst_n              (rst_n),
            .cmd                (cmd[i]),
            .sense              (sense[i]),
            .supply_ok          (supply_ok),
            .retry_cycles       (retry_cycles),
            .switch_closed      (switch_closed[i]),
            .detect_start       (detect_start[i]),
            .power_config_state (power_config_state[i]),
            .power_run_state    (power_run_state[2*i+1:2*i])
         );
      end
   endgenerate
endmodule
`default_nettype wire

// >>> sim/cpt_checker.sv
// Concurrent checks on connection 0 of the power transmitter controller
`default_nettype none
`include "cpt_defines.svh"
module cpt_checker (
   input wire logic                                 mclk,
   input wire logic                                 rst_n,
   input wire cpt_pkg::cpt_cmd_t [`CPT_NCONN-1:0]   cmd,
   input wire cpt_pkg::cpt_sense_t [`CPT_NCONN-1:0] sense,
   input wire logic                                 supply_input_ok,
   input wire logic                                 host_trigger,
   input wire logic [`CPT_NCONN-1:0]                switch_closed,
   input wire logic [`CPT_NCONN-1:0]                detect_start,
   input wire logic [`CPT_NCONN-1:0]                power_config_state,
   input wire logic [2*`CPT_NCONN-1:0]              power_run_state,
   input wire logic                                 trigger_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // Bench retry gap is 20 cycles; the margin covers the slowest answer
   localparam int RETRY_MAX = 64;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence fail_seen;
      !switch_closed[0] && power_config_state[0] && sense[0].detect_done && !sense[0].detect_ok;
   endsequence
   sequence auto_in_off;
      cmd[0].auto_power_cmd && power_config_state[0] == `CPT_CFG_OFF;
   endsequence
   start_on_auto_a: assert property (auto_in_off |=> detect_start[0] && power_config_state[0])
      else $error("auto command did not start detection");
   close_cause_a: assert property ($rose(switch_closed[0]) |-> $past(sense[0].detect_done && sense[0].detect_ok))
      else $error("switch closed without a good detection");
   retry_gap_a: assert property (fail_seen |=> !switch_closed[0] ##[0:RETRY_MAX] detect_start[0])
      else $error("failed detection not retried");
   run_match_a: assert property (switch_closed[0] == (power_run_state[1:0] == `CPT_RUN_ON))
      else $error("run state and switch disagree");
   off_opens_a: assert property (cmd[0].power_off_cmd |=> !switch_closed[0] && !power_config_state[0])
      else $error("off command left switch closed");
   off_quiet_a: assert property (!power_config_state[0] |-> !detect_start[0])
      else $error("detection started while off");
   supply_drop_a: assert property (switch_closed[0] && !supply_input_ok |-> ##[1:4] !switch_closed[0])
      else $error("switch stayed closed on supply loss");
   trip_hold_a: assert property (power_run_state[1:0] == `CPT_RUN_TRIPPED && !cmd[0].trip_clear_cmd
      && !cmd[0].power_off_cmd |=> power_run_state[1:0] == `CPT_RUN_TRIPPED && !switch_closed[0])
      else $error("tripped state not held");
   trig_delay_a: assert property (trigger_out == $past(host_trigger, 3))
      else $error("trigger output delay wrong");
endmodule
bind cpt_top cpt_checker chk_u (.mclk, .rst_n, .cmd, .sense, .supply_input_ok, .host_trigger, .switch_closed,
   .detect_start, .power_config_state, .power_run_state, .trigger_out);
`default_nettype wire

// >>> sim/cpt_camera_model.sv
// Cameras on the four cables, answering detection at differing speeds
`default_nettype none
`include "cpt_defines.svh"
module cpt_camera_model (
   input wire logic                                mclk,
   input wire logic                                rst_n,
   input wire logic [`CPT_NCONN-1:0]               detect_start,
   input wire logic [`CPT_NCONN-1:0]               switch_closed,
   input wire logic [`CPT_NCONN-1:0]               present,
   output var cpt_pkg::cpt_sense_t [`CPT_NCONN-1:0] sense
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] wait_q [`CPT_NCONN];
   always_ff @(posedge mclk or negedge rst_n) begin
      for (int i = 0; i < `CPT_NCONN; i++) begin
         if (!rst_n) begin
            wait_q[i] <= 4'h0;
            sense[i]  <= '0;
         end else begin
            // Later connections answer slower to vary the timing
            wait_q[i]             <= detect_start[i] ? 4'(3 + 2 * i) : (wait_q[i] != 4'h0 ? wait_q[i] - 4'h1 : 4'h0);
            sense[i].detect_done  <= (wait_q[i] == 4'h1);
            sense[i].detect_ok    <= present[i];
            sense[i].vout_dropped <= 1'b0;
            // An unpowered camera draws nothing
            sense[i].iout_ma      <= switch_closed[i] ? 12'h064 : 12'h000;
         end
      end
   end
endmodule
`default_nettype wire

// >>> sim/cable_power_transmitter_ctrl_bench.sv
// Self-checking bench for the power transmitter controller
`default_nettype none
`include "cpt_defines.svh"
module cable_power_transmitter_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {logic [1:0] conn; logic [2:0] op; logic [3:0] exp;} cpt_row_t;
   logic                                mclk, rst_n, aux, supply, trig, trigger_out;
   cpt_pkg::cpt_cmd_t [`CPT_NCONN-1:0]   cmd;
   cpt_pkg::cpt_sense_t [`CPT_NCONN-1:0] sense;
   logic [`CPT_NCONN-1:0]               sw, start, cfg, present;
   logic [2*`CPT_NCONN-1:0]             run;
   int                                  fails, comparisons, n;
   // Row: connection, command {auto,off,clear}, then expected {cfg, run, switch}
   cpt_row_t rows [7] = '{'{2'h1, 3'h2, 4'h0}, '{2'h1, 3'h1, 4'h0}, '{2'h1, 3'h4, 4'hB}, '{2'h1, 3'h4, 4'hB},
                          '{2'h2, 3'h1, 4'hB}, '{2'h2, 3'h2, 4'h0}, '{2'h2, 3'h4, 4'hB}};
   cpt_top dut_u (.mclk(mclk), .rst_n(rst_n), .cmd(cmd), .sense(sense), .aux_supply_connected(aux),
      .supply_input_ok(supply), .retry_cycles(32'h00000014), .host_trigger(trig), .switch_closed(sw),
      .detect_start(start), .power_config_state(cfg), .power_run_state(run), .trigger_out(trigger_out));
   cpt_camera_model cam_u (.mclk(mclk), .rst_n(rst_n), .detect_start(start), .switch_closed(sw),
      .present(present), .sense(sense));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic step(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic send(input int c, input logic [2:0] op);
      cmd[c] = op;
      step(1);
      cmd[c] = '0;
      // One idle cycle keeps back-to-back commands as separate pulses
      step(1);
   endtask
   // Bounded wait; a stuck switch ends the run
   task automatic wait_sw(input int c, input logic v);
      for (int i = 0; i < 300 && sw[c] !== v; i++) step(1);
      chk(8'(sw[c]), 8'(v), "switch wait");
      if (sw[c] !== v) complete_run();
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      step(8);
      chk({cfg, sw}, 8'hF0, "reset cfg and switch");
      chk(run, 8'h00, "reset run state");
      rst_n = 1'b1;
      for (int c = 0; c < `CPT_NCONN; c++) wait_sw(c, 1'b1);
      $display("Test done: reset and power-up");
   endtask
   initial begin
      {rst_n, aux, supply, trig, cmd, fails, comparisons} = '0;
      {aux, supply, present} = '1;
      do_reset();
      foreach (rows[r]) begin
         send(rows[r].conn, rows[r].op);
         step(60);
         chk(8'({cfg[rows[r].conn], run[2*rows[r].conn +: 2], sw[rows[r].conn]}), 8'(rows[r].exp),
            "row");
         chk(8'(sw[0]), 8'h01, "other connection");
         $display("Test done: row %0d", r);
      end
      supply = 1'b0;
      step(8);
      chk({cfg, sw}, 8'hF0, "supply loss");
      step(60);
      chk(run, 8'h00, "no run state on bad supply");
      chk({4'h0, sw}, 8'h00, "no power on bad supply");
      supply = 1'b1;
      wait_sw(0, 1'b1);
      $display("Test done: supply loss");
      send(3, 3'h2);
      aux = 1'b0;
      send(3, 3'h4);
      step(60);
      chk(8'(sw[3]), 8'h00, "aux cable missing");
      aux = 1'b1;
      wait_sw(3, 1'b1);
      $display("Test done: aux cable");
      present[0] = 1'b0;
      send(0, 3'h2);
      send(0, 3'h4);
      n = 0;
      repeat (100) begin
         step(1);
         n += int'(start[0]);
      end
      chk({7'h0, n >= 2}, 8'h01, "detection retried");
      chk(8'(sw[0]), 8'h00, "no camera stays open");
      present[0] = 1'b1;
      wait_sw(0, 1'b1);
      $display("Test done: absent camera");
      trig = 1'b1;
      step(2);
      chk(8'(trigger_out), 8'h00, "trigger early");
      step(1);
      chk(8'(trigger_out), 8'h01, "trigger on time");
      trig = 1'b0;
      step(5);
      $display("Test done: trigger");
      do_reset();
      complete_run();
   end
endmodule
`default_nettype wire
